// [hdl/apt_pkg.sv]
// shared constants for the converter phase timing and repeat block
package apt_pkg;

   // ****************************************
   // register map (byte-wide registers)
   // ****************************************
   localparam int unsigned ADDR_W          = 4;
   localparam logic [3:0]  ADDR_PRE_LO     = 4'h0;
   localparam logic [3:0]  ADDR_PRE_HI     = 4'h1;
   localparam logic [3:0]  ADDR_ACQ_LO     = 4'h2;
   localparam logic [3:0]  ADDR_ACQ_HI     = 4'h3;
   localparam logic [3:0]  ADDR_CAP        = 4'h4;
   localparam logic [3:0]  ADDR_RPT        = 4'h5;
   localparam logic [3:0]  ADDR_CNT        = 4'h6;
   localparam logic [3:0]  ADDR_FLT_HI     = 4'h7;
   localparam logic [3:0]  ADDR_CLK_SEL    = 4'h8;
   localparam logic [3:0]  ADDR_COMP_CTRL  = 4'h9;
   localparam logic [3:0]  ADDR_STATUS     = 4'hA;

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam int unsigned TIME_W          = 13;
   localparam int unsigned HI_W            = 5;
   localparam int unsigned CAP_W           = 5;
   localparam int unsigned CLKSEL_W        = 6;
   localparam int unsigned CNT_W           = 14;
   localparam int unsigned ACC_W           = 18;
   localparam int unsigned FLT_W           = 16;
   localparam int unsigned MODE_LSB        = 0;
   localparam int unsigned SHIFT_LSB       = 3;
   localparam int unsigned DUAL_BIT        = 6;
   localparam logic [7:0]  BYTE_RESET      = 8'h00;

   // ****************************************
   // computation modes and sequencer states
   // ****************************************
   localparam logic [2:0]  MODE_BASIC      = 3'h0;
   localparam logic [2:0]  MODE_ACCUM      = 3'h1;
   localparam logic [2:0]  MODE_AVERAGE    = 3'h2;
   localparam logic [2:0]  MODE_BURST      = 3'h3;
   localparam logic [2:0]  MODE_LPF        = 3'h4;

   // low two bits double as the stage status code
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PRE  = 2'b01,
      ST_ACQ  = 2'b10,
      ST_CONV = 2'b11
   } apt_state_e;

endpackage

// [hdl/apt_tick_if.sv]
// converter-clock tick and phase counter handshake between the timing modules
`timescale 1ns/1ps
interface apt_tick_if #(parameter int unsigned CNT_W = 14);
   logic             tick;
   logic             load;
   logic [CNT_W-1:0] loadValue;
   logic             done;

   modport div (output tick);
   modport cnt (input tick, input load, input loadValue, output done);
   modport seq (input tick, input done, output load, output loadValue);
endinterface

// [hdl/apt_clk_div.sv]
// converter clock divider: one tick every 2*(select+1) system clocks
`timescale 1ns/1ps
module apt_clk_div #(
   parameter int unsigned SEL_W = 6
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             clkEn,
   input wire logic             clear,
   input wire logic [SEL_W-1:0] divSelect,
   apt_tick_if.div              tickBus
);
   logic [SEL_W:0] divCount_reg;
   logic [SEL_W:0] divLimit;

   if (SEL_W < 1) begin : g_sel_check
      $error("apt_clk_div: SEL_W must be at least 1");
   end

   // period 2*(sel+1): count 0 .. 2*sel+1
   assign divLimit = {divSelect, 1'b1};
   assign tickBus.tick = clkEn && !clear && (divCount_reg == divLimit);

   // clear realigns the divider so a phase starts on a full converter period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divCount_reg <= '0;
      end else if (clkEn) begin
         if (clear || tickBus.tick) begin
            divCount_reg <= '0;
         end else begin
            divCount_reg <= divCount_reg + 1'b1;
         end
      end
   end
endmodule

// [hdl/apt_phase_cnt.sv]
// phase length counter: counts converter ticks down from the loaded length
`timescale 1ns/1ps
module apt_phase_cnt #(
   parameter int unsigned CNT_W = 14
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   apt_tick_if.cnt  tickBus
);
   logic [CNT_W-1:0] remain_reg;

   if (CNT_W < 2) begin : g_cnt_check
      $error("apt_phase_cnt: CNT_W must be at least 2");
   end

   // done must not look at load: the sequencer reloads in the cycle that raises done
   assign tickBus.done = tickBus.tick && (remain_reg == CNT_W'(1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remain_reg <= '0;
      end else if (clkEn) begin
         if (tickBus.load) begin
            remain_reg <= tickBus.loadValue;
         end else if (tickBus.tick && remain_reg != '0) begin
            remain_reg <= remain_reg - 1'b1;
         end
      end
   end
endmodule

// [hdl/apt_top.sv]
// converter phase timing, sample capacitor select, repeat counter and filter output
//
// Contract
// - A 13-bit precharge length (low byte plus 5-bit high field) of N nonzero lasts exactly N converter clocks.
// - A zero precharge length leaves the precharge phase out of the conversion.
// - A 13-bit acquisition length of N nonzero lasts N converter clocks.
// - Zero acquisition is skipped when precharge is zero, and lasts 8192 converter clocks otherwise.
// - The 5-bit capacitor code N switches in N one-picofarad units, zero none and 11111 all 31.
// - An 8-bit writable repeat limit sets how many triggers pass before the threshold check in repeat modes.
// - An 8-bit trigger tally counts triggers in repeat modes and against the limit decides when the check runs.
// - In accumulate, average and burst average modes the filter output is the accumulator shifted right.
// - In low-pass mode the filter output is the low-pass result, and its high byte is read-only.
// - Reset clears the timing, capacitor and limit registers; the tally is not reset.
// - The top three bits of the two high timing bytes and the capacitor byte read zero and ignore writes.
// - The converter clock is the system clock divided by 2 times (select + 1) with a 6-bit select.
// - Stage status reads 001/010/011 for the first stage phases and 101/110/111 for the second.
`timescale 1ns/1ps
module apt_top #(
   parameter int unsigned ACQ_ZERO_CLOCKS = 8192,
   parameter int unsigned CONV_CLOCKS     = 12
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       clkEn,
   input  wire logic [apt_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [7:0]                 regWrData,
   input  wire logic                       regWrEn,
   input  wire logic                       regRdEn,
   output logic      [7:0]                 regRdData,
   input  wire logic                       convStart,
   input  wire logic [apt_pkg::ACC_W-1:0]  accumulatorValue,
   input  wire logic [apt_pkg::FLT_W-1:0]  lpfResult,
   output logic      [30:0]                capEnable,
   output logic      [2:0]                 stageStatus,
   output logic                            prechargeOn,
   output logic                            acquireOn,
   output logic                            convertOn,
   output logic                            convDone,
   output logic                            thresholdCheck
);
   localparam int unsigned CW        = apt_pkg::CNT_W;
   localparam int unsigned CAP_LINES = (1 << apt_pkg::CAP_W) - 1;
   localparam logic [CW-1:0] ACQ_ZERO_LEN = CW'(ACQ_ZERO_CLOCKS);
   localparam logic [CW-1:0] CONV_LEN     = CW'(CONV_CLOCKS);

   if (ACQ_ZERO_CLOCKS < 1 || ACQ_ZERO_CLOCKS >= (1 << CW) || CONV_CLOCKS < 1 || CONV_CLOCKS >= (1 << CW))
   begin : g_len_check
      $error("apt_top: phase lengths must fit the phase counter and be nonzero");
   end

   // ****************************************
   // registers
   // ****************************************
   logic [7:0]                     preLo_reg;
   logic [apt_pkg::HI_W-1:0]       preHi_reg;
   logic [7:0]                     acqLo_reg;
   logic [apt_pkg::HI_W-1:0]       acqHi_reg;
   logic [apt_pkg::CAP_W-1:0]      capCode_reg;
   logic [7:0]                     repeatLimit_reg;
   logic [7:0]                     triggerTally_reg;
   logic [apt_pkg::CLKSEL_W-1:0]   clkSel_reg;
   logic [6:0]                     compCtrl_reg;
   logic [apt_pkg::FLT_W-1:0]      filterOutput_reg;
   logic                           secondStage_reg;
   logic                           secondStage_next;
   apt_pkg::apt_state_e            state_reg;
   apt_pkg::apt_state_e            state_next;

   logic [apt_pkg::TIME_W-1:0]     precharge_setting;
   logic [apt_pkg::TIME_W-1:0]     acquisition_setting;
   logic [CW-1:0]                  acquisitionCount;
   logic [2:0]                     computeMode;
   logic [2:0]                     rightShiftAmount;
   logic                           repeatMode;
   logic [8:0]                     tallyPlusOne;
   logic [apt_pkg::ACC_W-1:0]      shiftedAcc;
   logic [CAP_LINES-1:0]           capEnableNext;
   logic                           wrHit;
   apt_pkg::apt_state_e            firstState;
   logic [CW-1:0]                  firstLen;
   logic                           convDoneNext;

   apt_tick_if #(.CNT_W(CW)) tickBus();

   assign precharge_setting   = {preHi_reg, preLo_reg};
   assign acquisition_setting = {acqHi_reg, acqLo_reg};
   assign computeMode         = compCtrl_reg[apt_pkg::MODE_LSB +: 3];
   assign rightShiftAmount    = compCtrl_reg[apt_pkg::SHIFT_LSB +: 3];
   assign wrHit               = regWrEn && clkEn;

   // ****************************************
   // register writes
   // ****************************************
   // high fields keep only their implemented bits; filter high byte takes no write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preLo_reg       <= apt_pkg::BYTE_RESET;
         preHi_reg       <= apt_pkg::BYTE_RESET[apt_pkg::HI_W-1:0];
         acqLo_reg       <= apt_pkg::BYTE_RESET;
         acqHi_reg       <= apt_pkg::BYTE_RESET[apt_pkg::HI_W-1:0];
         capCode_reg     <= apt_pkg::BYTE_RESET[apt_pkg::CAP_W-1:0];
         repeatLimit_reg <= apt_pkg::BYTE_RESET;
         clkSel_reg      <= apt_pkg::BYTE_RESET[apt_pkg::CLKSEL_W-1:0];
         compCtrl_reg    <= apt_pkg::BYTE_RESET[6:0];
      end else if (wrHit) begin
         unique case (regAddr)
            apt_pkg::ADDR_PRE_LO:    preLo_reg       <= regWrData;
            apt_pkg::ADDR_PRE_HI:    preHi_reg       <= regWrData[apt_pkg::HI_W-1:0];
            apt_pkg::ADDR_ACQ_LO:    acqLo_reg       <= regWrData;
            apt_pkg::ADDR_ACQ_HI:    acqHi_reg       <= regWrData[apt_pkg::HI_W-1:0];
            apt_pkg::ADDR_CAP:       capCode_reg     <= regWrData[apt_pkg::CAP_W-1:0];
            apt_pkg::ADDR_RPT:       repeatLimit_reg <= regWrData;
            apt_pkg::ADDR_CLK_SEL:   clkSel_reg      <= regWrData[apt_pkg::CLKSEL_W-1:0];
            apt_pkg::ADDR_COMP_CTRL: compCtrl_reg    <= regWrData[6:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= apt_pkg::BYTE_RESET;
      end else if (clkEn) begin
         regRdData <= apt_pkg::BYTE_RESET;
         if (regRdEn) begin
            unique case (regAddr)
               apt_pkg::ADDR_PRE_LO:    regRdData <= preLo_reg;
               apt_pkg::ADDR_PRE_HI:    regRdData <= {3'h0, preHi_reg};
               apt_pkg::ADDR_ACQ_LO:    regRdData <= acqLo_reg;
               apt_pkg::ADDR_ACQ_HI:    regRdData <= {3'h0, acqHi_reg};
               apt_pkg::ADDR_CAP:       regRdData <= {3'h0, capCode_reg};
               apt_pkg::ADDR_RPT:       regRdData <= repeatLimit_reg;
               apt_pkg::ADDR_CNT:       regRdData <= triggerTally_reg;
               apt_pkg::ADDR_FLT_HI:    regRdData <= filterOutput_reg[15:8];
               apt_pkg::ADDR_CLK_SEL:   regRdData <= {2'h0, clkSel_reg};
               apt_pkg::ADDR_COMP_CTRL: regRdData <= {1'b0, compCtrl_reg};
               apt_pkg::ADDR_STATUS:    regRdData <= {5'h00, stageStatus};
               default:                 regRdData <= apt_pkg::BYTE_RESET;
            endcase
         end
      end
   end

   // ****************************************
   // converter clock and phase counter
   // ****************************************
   apt_clk_div #(.SEL_W(apt_pkg::CLKSEL_W)) u_div (
      .clk       (clk),
      .rst       (rst),
      .clkEn     (clkEn),
      .clear     (state_reg == apt_pkg::ST_IDLE),
      .divSelect (clkSel_reg),
      .tickBus   (tickBus.div)
   );

   apt_phase_cnt #(.CNT_W(CW)) u_cnt (
      .clk     (clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .tickBus (tickBus.cnt)
   );

   // ****************************************
   // phase sequencer
   // ****************************************
   // zero acquisition with precharge on takes the long default, not the 256 of the older note
   assign acquisitionCount = (acquisition_setting != '0) ? {1'b0, acquisition_setting} :
                             (precharge_setting != '0) ? ACQ_ZERO_LEN : '0;

   always_comb begin
      if (precharge_setting != '0) begin
         firstState = apt_pkg::ST_PRE;
         firstLen   = {1'b0, precharge_setting};
      end else if (acquisitionCount != '0) begin
         firstState = apt_pkg::ST_ACQ;
         firstLen   = acquisitionCount;
      end else begin
         firstState = apt_pkg::ST_CONV;
         firstLen   = CONV_LEN;
      end
   end
   always_comb begin
      state_next        = state_reg;
      secondStage_next  = secondStage_reg;
      tickBus.load      = 1'b0;
      tickBus.loadValue = '0;
      convDoneNext      = 1'b0;
      if (clkEn) begin
         unique case (state_reg)
            apt_pkg::ST_IDLE: begin
               if (convStart) begin
                  state_next        = firstState;
                  secondStage_next  = 1'b0;
                  tickBus.load      = 1'b1;
                  tickBus.loadValue = firstLen;
               end
            end
            apt_pkg::ST_PRE: begin
               if (tickBus.done) begin
                  tickBus.load = 1'b1;
                  if (acquisitionCount != '0) begin
                     state_next        = apt_pkg::ST_ACQ;
                     tickBus.loadValue = acquisitionCount;
                  end else begin
                     state_next        = apt_pkg::ST_CONV;
                     tickBus.loadValue = CONV_LEN;
                  end
               end
            end
            apt_pkg::ST_ACQ: begin
               if (tickBus.done) begin
                  state_next        = apt_pkg::ST_CONV;
                  tickBus.load      = 1'b1;
                  tickBus.loadValue = CONV_LEN;
               end
            end
            apt_pkg::ST_CONV: begin
               if (tickBus.done) begin
                  if (compCtrl_reg[apt_pkg::DUAL_BIT] && !secondStage_reg) begin
                     state_next        = firstState;
                     secondStage_next  = 1'b1;
                     tickBus.load      = 1'b1;
                     tickBus.loadValue = firstLen;
                  end else begin
                     state_next   = apt_pkg::ST_IDLE;
                     convDoneNext = 1'b1;
                  end
               end
            end
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg       <= apt_pkg::ST_IDLE;
         secondStage_reg <= 1'b0;
      end else begin
         state_reg       <= state_next;
         secondStage_reg <= secondStage_next;
      end
   end
   // outputs follow the next state so they line up with the state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stageStatus <= 3'h0;
         prechargeOn <= 1'b0;
         acquireOn   <= 1'b0;
         convertOn   <= 1'b0;
         convDone    <= 1'b0;
      end else if (clkEn) begin
         stageStatus <= (state_next == apt_pkg::ST_IDLE) ? 3'h0 : {secondStage_next, state_next};
         prechargeOn <= state_next == apt_pkg::ST_PRE;
         acquireOn   <= state_next == apt_pkg::ST_ACQ;
         convertOn   <= state_next == apt_pkg::ST_CONV;
         convDone    <= convDoneNext;
      end
   end

   // ****************************************
   // extra sample capacitance
   // ****************************************
   for (genvar i = 0; i < CAP_LINES; i++) begin : g_cap
      assign capEnableNext[i] = capCode_reg > apt_pkg::CAP_W'(i);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         capEnable <= '0;
      end else if (clkEn) begin
         capEnable <= capEnableNext;
      end
   end

   // ****************************************
   // repeat tally and threshold check
   // ****************************************
   assign repeatMode   = computeMode == apt_pkg::MODE_LPF || computeMode == apt_pkg::MODE_BURST ||
                         computeMode == apt_pkg::MODE_AVERAGE;
   assign tallyPlusOne = {1'b0, triggerTally_reg} + 9'h001;
   // no reset on purpose: the tally survives resets and powers up unknown
   always_ff @(posedge clk) begin
      if (clkEn) begin
         if (regWrEn && regAddr == apt_pkg::ADDR_CNT) begin
            triggerTally_reg <= regWrData;
         end else if (convDoneNext && repeatMode) begin
            triggerTally_reg <= (tallyPlusOne >= {1'b0, repeatLimit_reg}) ? 8'h00 : tallyPlusOne[7:0];
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         thresholdCheck <= 1'b0;
      end else if (clkEn) begin
         thresholdCheck <= convDoneNext && repeatMode && (tallyPlusOne >= {1'b0, repeatLimit_reg});
      end
   end

   // ****************************************
   // filter output
   // ****************************************
   assign shiftedAcc = accumulatorValue >> rightShiftAmount;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filterOutput_reg <= '0;
      end else if (clkEn) begin
         if (computeMode == apt_pkg::MODE_LPF) begin
            filterOutput_reg <= lpfResult;
         end else if (computeMode != apt_pkg::MODE_BASIC) begin
            filterOutput_reg <= shiftedAcc[apt_pkg::FLT_W-1:0];
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [CW-1:0] phaseTicks;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phaseTicks <= '0;
      end else if (state_next != state_reg || tickBus.load) begin
         phaseTicks <= '0;
      end else if (tickBus.tick) begin
         phaseTicks <= phaseTicks + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_leave_pre;
      state_reg == apt_pkg::ST_PRE && tickBus.done;
   endsequence
   sequence s_leave_acq;
      state_reg == apt_pkg::ST_ACQ && tickBus.done;
   endsequence
   sequence s_start;
      state_reg == apt_pkg::ST_IDLE && convStart && clkEn;
   endsequence
   a_pre_length: assert property (s_leave_pre |-> phaseTicks + 1'b1 == {1'b0, precharge_setting})
      else $error("precharge phase length differs from setting");
   a_pre_skip: assert property (s_start ##0 (precharge_setting == '0) |=> state_reg != apt_pkg::ST_PRE)
      else $error("zero precharge did not skip the phase");
   a_acq_length: assert property (s_leave_acq |-> phaseTicks + 1'b1 == acquisitionCount)
      else $error("acquisition phase length differs from setting");
   a_acq_zero_both: assert property (s_start ##0 (precharge_setting == '0 && acquisition_setting == '0)
      |=> state_reg == apt_pkg::ST_CONV && convertOn)
      else $error("zero precharge and acquisition did not go straight to conversion");
   a_cap_decode: assert property (clkEn |=> $countones(capEnable) == $past(capCode_reg))
      else $error("capacitor enables do not match the code");
   a_high_reserved: assert property (regRdEn && clkEn && (regAddr == apt_pkg::ADDR_PRE_HI ||
      regAddr == apt_pkg::ADDR_ACQ_HI || regAddr == apt_pkg::ADDR_CAP) |=> regRdData[7:5] == 3'h0)
      else $error("unimplemented high bits read nonzero");
   a_stage_code: assert property (state_reg != apt_pkg::ST_IDLE && !$changed(state_reg)
      |-> stageStatus == {secondStage_reg, state_reg})
      else $error("stage status does not match the phase");
   a_phase_order: assert property (s_leave_pre |=> state_reg == apt_pkg::ST_ACQ ||
      (acquisitionCount == '0 && state_reg == apt_pkg::ST_CONV) ##1 !prechargeOn)
      else $error("precharge was not followed by acquisition or conversion");
   a_filter_shift: assert property (clkEn && (computeMode == apt_pkg::MODE_ACCUM || computeMode == apt_pkg::MODE_BURST)
      |=> filterOutput_reg == $past(shiftedAcc[apt_pkg::FLT_W-1:0]))
      else $error("filter output is not the shifted accumulator");
endmodule

// [test/apt_front_model.sv]
// front end model: times each sampling phase and records the stage codes seen
`timescale 1ns/1ps
module apt_front_model (
   input  wire logic       clk,
   input  wire logic       convStart,
   input  wire logic       prechargeOn,
   input  wire logic       acquireOn,
   input  wire logic       convertOn,
   input  wire logic [2:0] stageStatus,
   output int              preLen,
   output int              acqLen,
   output int              convLen,
   output logic [8:0]      stSeen
);
   // lengths in system clocks, so a wrong divider shows as well
   always @(posedge clk) begin
      if (convStart) begin
         preLen <= 0;
         acqLen <= 0;
         convLen <= 0;
      end else begin
         preLen <= preLen + int'(prechargeOn);
         acqLen <= acqLen + int'(acquireOn);
         convLen <= convLen + int'(convertOn);
      end
      if (prechargeOn) stSeen[8:6] <= stageStatus;
      if (acquireOn) stSeen[5:3] <= stageStatus;
      if (convertOn) stSeen[2:0] <= stageStatus;
   end
endmodule

// [test/testbench.sv]
// self-checking bench for the phase timing and repeat block
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // signals and instances
   // ****************************************
   localparam int ACQZ = 16;
   logic clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, convStart = 1'b0, clkEn = 1'b1, tc;
   logic [3:0]  regAddr = 4'h0;
   logic [7:0]  regWrData = 8'h00, regRdData;
   logic [17:0] accumulatorValue = 18'h00000;
   logic [15:0] lpfResult = 16'h0000;
   logic [30:0] capEnable;
   logic [2:0]  stageStatus;
   logic [8:0]  stSeen;
   logic        prechargeOn, acquireOn, convertOn, convDone, thresholdCheck;
   int          preLen, acqLen, convLen, errCount = 0, checksDone = 0, cycles = 0;
   apt_top #(.ACQ_ZERO_CLOCKS(ACQZ), .CONV_CLOCKS(2)) apt_top_inst (.clk(clk), .rst(rst), .clkEn(clkEn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .convStart(convStart), .accumulatorValue(accumulatorValue), .lpfResult(lpfResult), .capEnable(capEnable),
      .stageStatus(stageStatus), .prechargeOn(prechargeOn), .acquireOn(acquireOn), .convertOn(convertOn),
      .convDone(convDone), .thresholdCheck(thresholdCheck));
   apt_front_model apt_front_model_inst (.clk(clk), .convStart(convStart), .prechargeOn(prechargeOn),
      .acquireOn(acquireOn), .convertOn(convertOn), .stageStatus(stageStatus), .preLen(preLen),
      .acqLen(acqLen), .convLen(convLen), .stSeen(stSeen));
   always #5 clk = ~clk;
   // a hang costs at most this many cycles; the whole run needs under two thousand
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         finishTest();
      end
   end
   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic finishTest;
      if (errCount == 0 && checksDone > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         errCount++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1 chk("regRdData", regRdData, exp);
   endtask
   task automatic conv;
      @(posedge clk);
      convStart <= 1'b1;
      @(posedge clk);
      convStart <= 1'b0;
      for (int i = 0; i < 3000 && convDone !== 1'b1; i++) @(posedge clk) #1;
      chk("convDone", convDone, 1'b1);
      tc = thresholdCheck;
   endtask
   // phase lengths are ticks times the divider period 2*(sel+1)
   task automatic tim(input logic [12:0] p, input logic [12:0] q, input logic [7:0] s, input int qt);
      wr(4'h0, p[7:0]);
      wr(4'h1, {3'b000, p[12:8]});
      wr(4'h2, q[7:0]);
      wr(4'h3, {3'b000, q[12:8]});
      wr(4'h8, s);
      conv();
      chk("preLen", preLen, p * 2 * (s + 1));
      chk("acqLen", acqLen, qt * 2 * (s + 1));
      chk("convLen", convLen, 4 * (s + 1));
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00);
      rd(4'hB, 8'h00);
      wr(4'h6, 8'h2A);
      wr(4'h5, 8'h07);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(4'h6, 8'h2A);
      rd(4'h5, 8'h00);
      for (int a = 1; a < 5; a += (a == 1) ? 2 : 1) begin
         wr(a[3:0], 8'hFF);
         rd(a[3:0], 8'h1F);
      end
      for (int c = 0; c < 32; c += (c == 0) ? 5 : 26) begin
         wr(4'h4, c[7:0]);
         @(posedge clk) #1;
         chk("capEnable", capEnable, (32'h1 << c) - 32'h1);
      end
      tim(13'h0101, 13'h0002, 8'h00, 2);
      chk("stSeen", stSeen, 9'h053);
      wr(4'h9, 8'h40);
      conv();
      chk("stSeen", stSeen, 9'h177);
      chk("preLen", preLen, 1028);
      wr(4'h9, 8'h00);
      tim(13'h0001, 13'h0003, 8'h01, 3);
      tim(13'h0000, 13'h0003, 8'h00, 3);
      tim(13'h0000, 13'h0000, 8'h00, 0);
      tim(13'h0001, 13'h0000, 8'h00, ACQZ);
      wr(4'h0, 8'h00);
      wr(4'h9, 8'h02);
      wr(4'h5, 8'h03);
      wr(4'h6, 8'h00);
      conv();
      chk("thresholdCheck", tc, 1'b0);
      rd(4'h6, 8'h01);
      conv();
      chk("thresholdCheck", tc, 1'b0);
      conv();
      chk("thresholdCheck", tc, 1'b1);
      rd(4'h6, 8'h00);
      clkEn <= 1'b0;
      wr(4'h5, 8'h55);
      clkEn <= 1'b1;
      rd(4'h5, 8'h03);
      @(posedge clk);
      accumulatorValue <= 18'h12345;
      lpfResult <= 16'hA5C3;
      wr(4'h9, 8'h11);
      rd(4'h7, 8'h48);
      wr(4'h9, 8'h04);
      wr(4'h7, 8'h00);
      rd(4'h7, 8'hA5);
      finishTest();
   end
endmodule
